// ==== pkg/flash_cmd_pkg.sv ====
// constants shared by the serial flash command port
package flash_cmd_pkg;

    // ==========================================================
    // command opcodes
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] READ_IDENTIFICATION_CMD = 8'h9F;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] NORMAL_READ_CMD = 8'h03;
    localparam logic [7:0] FAST_READ_CMD = 8'h0B;
    localparam logic [7:0] DUAL_OUTPUT_READ_CMD = 8'h3B;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
    localparam logic [7:0] BLOCK_ERASE_CMD_A = 8'h52;
    localparam logic [7:0] BLOCK_ERASE_CMD_B = 8'hD8;
    localparam logic [7:0] CHIP_ERASE_CMD_A = 8'h60;
    localparam logic [7:0] CHIP_ERASE_CMD_B = 8'hC7;
    localparam logic [7:0] DEEP_POWER_DOWN_CMD = 8'hB9;
    localparam logic [7:0] SIGNATURE_READ_CMD = 8'hAB;
    localparam logic [7:0] MAKER_DEVICE_ID_READ_CMD = 8'h90;

    // ==========================================================
    // frame layout, in bits received since chip select fell
    localparam logic [15:0] OPCODE_BITS = 16'h0008;
    localparam logic [15:0] STATUS_WRITE_BITS = 16'h0010;
    localparam logic [15:0] ADDR_END_BITS = 16'h0020;
    localparam logic [15:0] DUMMY_END_BITS = 16'h0028;

    // ==========================================================
    // storage, status layout and delivery contents
    localparam int ADDR_W = 8;
    localparam int ARRAY_BYTES = 256;
    localparam int PAGE_W = 4;
    localparam int PAGE_BYTES = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_WEL_BIT = 1;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] ARRAY_ERASED = 8'hFF;

    // identification bytes: values are arbitrary
    localparam logic [7:0] MAKER_CODE = 8'hA5;
    localparam logic [7:0] MEMORY_TYPE_CODE = 8'h5A;
    localparam logic [7:0] DENSITY_CODE = 8'h10;
    localparam logic [7:0] DEVICE_CODE = 8'h3C;
    localparam logic [7:0] SIGNATURE_CODE = 8'h3C;

    // ==========================================================
    // host clock ceilings, MHz
    localparam int NORMAL_READ_MAX_MHZ = 33;
    localparam int DUAL_READ_MAX_MHZ = 80;
    localparam int OTHER_CMD_MAX_MHZ = 104;

    // ==========================================================
    // timing, in the printed units, and derived core clock counts
    localparam int CLK_MHZ = 100;
    localparam int T_DPD_US = 10;
    localparam real T_WAKE_US = 8.8;
    localparam int T_STATUS_WRITE_MS = 40;
    localparam int T_STATUS_WRITE_TYP_MS = 5;
    localparam int T_PAGE_PROGRAM_MS = 3;
    localparam int T_BYTE_PROGRAM_US = 50;
    localparam int T_SECTOR_ERASE_MS = 200;
    localparam int T_BLOCK_ERASE_S = 2;
    localparam int T_CHIP_ERASE_S = 2;

    localparam int DPD_CYC = T_DPD_US * CLK_MHZ;
    localparam int WAKE_CYC = int'($floor(T_WAKE_US * real'(CLK_MHZ)));
    localparam int STATUS_WRITE_CYC = T_STATUS_WRITE_MS * 1000 * CLK_MHZ;
    localparam int PAGE_PROGRAM_CYC = T_PAGE_PROGRAM_MS * 1000 * CLK_MHZ;
    localparam int SECTOR_ERASE_CYC = T_SECTOR_ERASE_MS * 1000 * CLK_MHZ;
    localparam int BLOCK_ERASE_CYC = T_BLOCK_ERASE_S * 1000000 * CLK_MHZ;
    localparam int CHIP_ERASE_CYC = T_CHIP_ERASE_S * 1000000 * CLK_MHZ;

    // ==========================================================
    // power and cycle states, gray along standby -> down -> wake
    typedef enum logic [2:0] {
        ST_STANDBY = 3'h0,
        ST_ENTER_DOWN = 3'h1,
        ST_DEEP_DOWN = 3'h3,
        ST_WAKING = 3'h2,
        ST_BUSY = 3'h4
    } pwr_e;

endpackage : flash_cmd_pkg

// ==== logic/level_sync.sv ====
// multi-stage synchroniser for slowly changing levels
`timescale 1ns/1ns
`default_nettype none

module level_sync #(
    parameter int W = 1,
    parameter int STAGES = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o,
    output logic [W-1:0] q_prev_o
);

    // ==========================================================
    // stage chain; only the last two stages leave the module
    logic [STAGES-1:0][W-1:0] stg_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stg_q <= {STAGES{RST_VAL}};
        end else begin
            stg_q <= {stg_q[STAGES-2:0], d_i};
        end
    end

    assign q_o = stg_q[STAGES-1];
    assign q_prev_o = stg_q[STAGES-2];

endmodule : level_sync

`default_nettype wire

// ==== logic/serial_flash_command_port.sv ====
// serial flash command port: link-side decoder and core-side array, status and timers
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - opcode 06 sets write-enable latch
// - opcode 04 clears write-enable latch
// - opcode 9F shifts identification bytes out
// - opcode 05 repeats status byte while selected
// - opcode 01 plus byte writes status
// - opcode 03 plus address reads array
// - opcode 0B reads array at full rate
// - opcode 3B reads array on two lines
// - opcode 02 plus address programs page
// - opcode 20 erases addressed sector
// - opcodes 52 or D8 erase block
// - opcodes 60 or C7 erase whole array
// - opcode B9 enters deep power-down
// - opcode AB wakes, also returns signature
// - opcode 90 address picks ID order
// - deep power-down reached within 10 us
// - wake to standby within 8.8 us
// - array delivered FFh, status 00h
// - power-up in standby, latch cleared

module serial_flash_command_port
    import flash_cmd_pkg::*;
#(
    parameter int unsigned STATUS_WRITE_CYCLES = STATUS_WRITE_CYC,
    parameter int unsigned PAGE_PROGRAM_CYCLES = PAGE_PROGRAM_CYC,
    parameter int unsigned SECTOR_ERASE_CYCLES = SECTOR_ERASE_CYC,
    parameter int unsigned BLOCK_ERASE_CYCLES = BLOCK_ERASE_CYC,
    parameter int unsigned CHIP_ERASE_CYCLES = CHIP_ERASE_CYC
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic sio0_o,
    output logic sio0_oe_o,
    output logic sio1_o,
    output logic sio1_oe_o,
    output logic busy_o,
    output logic deep_power_down_o
);

    // ==========================================================
    // state types
    typedef struct packed {
        logic [15:0] cnt;
        logic [7:0] op;
        logic [7:0] sh;
        logic [23:0] addr;
        logic [7:0] wdat;
        logic [PAGE_BYTES-1:0][7:0] pbuf;
        logic [PAGE_BYTES-1:0] pmask;
        logic [8:0] stat;
    } link_s;

    typedef struct packed {
        logic sio0;
        logic sio0_oe;
        logic sio1;
        logic sio1_oe;
    } drive_s;

    typedef struct packed {
        pwr_e st;
        logic [31:0] tmr;
        logic write_enable_latch;
        logic [5:0] prot;
        logic cs_hi;
        logic busy;
        logic dpd;
        logic [ARRAY_BYTES-1:0][7:0] mem;
    } core_s;

    link_s lk_q;
    link_s lk_d;
    drive_s dr_q;
    drive_s dr_d;
    core_s core_q;
    core_s core_d;
    logic in_frame_q;
    logic link_rst;
    logic cs_sync;
    logic cs_sync_prev;
    logic [8:0] stat_sync;
    logic [8:0] stat_sync_prev;
    logic [7:0] status_byte;

    assign link_rst = sys_rst_i | cs_n_i;
    assign status_byte = {core_q.prot, core_q.write_enable_latch, core_q.busy};

    // ==========================================================
    // crossings
    // chip select enters the core domain through three stages
    level_sync #(.W(1), .STAGES(3), .RST_VAL(1'b1)) u_cs_sync (
        .clk_i(mclk_i),
        .rst_i(sys_rst_i),
        .d_i(cs_n_i),
        .q_o(cs_sync),
        .q_prev_o(cs_sync_prev)
    );

    // status and power-down flag can also change mid-frame when a timer ends, so
    // the held copy takes them on any link edge where the last two stages agree
    level_sync #(.W(9), .STAGES(3), .RST_VAL(9'h000)) u_stat_sync (
        .clk_i(sclk_i),
        .rst_i(sys_rst_i),
        .d_i({core_q.dpd, status_byte}),
        .q_o(stat_sync),
        .q_prev_o(stat_sync_prev)
    );

    // ==========================================================
    // link side: frame marker, cleared whenever the host deselects
    always_ff @(posedge sclk_i or posedge link_rst) begin
        if (link_rst) begin
            in_frame_q <= 1'b0;
        end else begin
            in_frame_q <= 1'b1;
        end
    end

    // ==========================================================
    // link side: input shifter and command capture
    always_comb begin
        logic [7:0] byte_in;
        logic [15:0] cnt_n;
        logic [15:0] dpos;
        logic [PAGE_W-1:0] slot;
        byte_in = {lk_q.sh[6:0], si_i};
        cnt_n = 16'h0001;
        dpos = 16'h0000;
        slot = '0;
        lk_d = lk_q;
        lk_d.sh = byte_in;
        if (stat_sync == stat_sync_prev) begin
            lk_d.stat = stat_sync;
        end
        if (in_frame_q) begin
            cnt_n = (lk_q.cnt == 16'hFFFF) ? lk_q.cnt : lk_q.cnt + 16'h0001;
        end
        lk_d.cnt = cnt_n;
        if (cnt_n == OPCODE_BITS) begin
            lk_d.op = byte_in;
            lk_d.pmask = '0;
        end else if (cnt_n > OPCODE_BITS && cnt_n <= ADDR_END_BITS && cnt_n[2:0] == 3'h0) begin
            lk_d.addr = {lk_q.addr[15:0], byte_in};
        end
        if (cnt_n == STATUS_WRITE_BITS) begin
            lk_d.wdat = byte_in;
        end
        if (lk_q.op == PAGE_PROGRAM_CMD && cnt_n > ADDR_END_BITS && cnt_n[2:0] == 3'h0) begin
            // bytes past the page end wrap inside the page, later ones win
            dpos = cnt_n - DUMMY_END_BITS;
            slot = PAGE_W'(lk_q.addr[PAGE_W-1:0] + dpos[PAGE_W+2:3]);
            lk_d.pbuf[slot] = byte_in;
            lk_d.pmask[slot] = 1'b1;
        end
    end

    always_ff @(posedge sclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lk_q <= '0;
        end else begin
            lk_q <= lk_d;
        end
    end

    // ==========================================================
    // link side: output data, launched on the falling clock edge
    always_comb begin
        logic [15:0] start;
        logic [15:0] pos;
        logic [7:0] j;
        logic [7:0] tx;
        logic dual;
        logic en;
        logic active;
        logic [2:0] bsel;
        start = OPCODE_BITS;
        tx = 8'h00;
        bsel = 3'h0;
        dual = 1'b0;
        en = 1'b1;
        unique case (lk_q.op)
            NORMAL_READ_CMD: start = ADDR_END_BITS;
            FAST_READ_CMD: start = DUMMY_END_BITS;
            DUAL_OUTPUT_READ_CMD: begin
                start = DUMMY_END_BITS;
                dual = 1'b1;
            end
            READ_IDENTIFICATION_CMD: start = OPCODE_BITS;
            STATUS_READ_CMD: start = OPCODE_BITS;
            SIGNATURE_READ_CMD: start = ADDR_END_BITS;
            MAKER_DEVICE_ID_READ_CMD: start = ADDR_END_BITS;
            default: en = 1'b0;
        endcase
        // deep power-down answers nothing but the signature read
        active = en && (lk_q.cnt >= start) && (!lk_q.stat[8] || lk_q.op == SIGNATURE_READ_CMD);
        pos = lk_q.cnt - start;
        j = dual ? pos[9:2] : pos[10:3];
        unique case (lk_q.op)
            READ_IDENTIFICATION_CMD: begin
                tx = (j == 8'h00) ? MAKER_CODE : (j == 8'h01) ? MEMORY_TYPE_CODE : DENSITY_CODE;
            end
            STATUS_READ_CMD: tx = lk_q.stat[7:0];
            SIGNATURE_READ_CMD: tx = SIGNATURE_CODE;
            MAKER_DEVICE_ID_READ_CMD: tx = (lk_q.addr[0] ^ j[0]) ? DEVICE_CODE : MAKER_CODE;
            default: tx = core_q.mem[ADDR_W'(lk_q.addr[ADDR_W-1:0] + j)];
        endcase
        dr_d = '0;
        if (dual) begin
            bsel = {~pos[1:0], 1'b1};
            dr_d.sio1 = tx[bsel];
            dr_d.sio0 = tx[{~pos[1:0], 1'b0}];
            dr_d.sio0_oe = active;
        end else begin
            bsel = ~pos[2:0];
            dr_d.sio1 = tx[bsel];
        end
        dr_d.sio1_oe = active;
    end

    // deselect releases both lines at once
    always_ff @(negedge sclk_i or posedge link_rst) begin
        if (link_rst) begin
            dr_q <= '0;
        end else begin
            dr_q <= dr_d;
        end
    end

    assign sio0_o = dr_q.sio0;
    assign sio0_oe_o = dr_q.sio0_oe;
    assign sio1_o = dr_q.sio1;
    assign sio1_oe_o = dr_q.sio1_oe;

    // ==========================================================
    // core side: command execution at frame end, power and busy timers
    // captured link fields are read only after deselect is seen here;
    // the link clock is stopped then, so they hold still
    always_comb begin
        logic cs_rise;
        logic wr_ok;
        logic [7:0] op;
        logic [15:0] cnt;
        op = lk_q.op;
        cnt = lk_q.cnt;
        cs_rise = (cs_sync == cs_sync_prev) && cs_sync && !core_q.cs_hi;
        wr_ok = core_q.write_enable_latch;
        core_d = core_q;
        if (cs_sync == cs_sync_prev) begin
            core_d.cs_hi = cs_sync;
        end
        unique case (core_q.st)
            ST_STANDBY: begin
                if (cs_rise) begin
                    if (op == WRITE_ENABLE_CMD && cnt == OPCODE_BITS) begin
                        core_d.write_enable_latch = 1'b1;
                    end else if (op == WRITE_DISABLE_CMD && cnt == OPCODE_BITS) begin
                        core_d.write_enable_latch = 1'b0;
                    end else if (op == STATUS_WRITE_CMD && cnt == STATUS_WRITE_BITS && wr_ok) begin
                        core_d.prot = lk_q.wdat[7:2];
                        core_d.write_enable_latch = 1'b0;
                        core_d.st = ST_BUSY;
                        core_d.tmr = STATUS_WRITE_CYCLES;
                    end else if (op == PAGE_PROGRAM_CMD && cnt > ADDR_END_BITS
                                 && cnt[2:0] == 3'h0 && wr_ok) begin
                        for (int k = 0; k < PAGE_BYTES; k++) begin
                            if (lk_q.pmask[k]) begin
                                // programming only clears bits
                                core_d.mem[{lk_q.addr[ADDR_W-1:PAGE_W], PAGE_W'(k)}] =
                                    core_q.mem[{lk_q.addr[ADDR_W-1:PAGE_W], PAGE_W'(k)}]
                                    & lk_q.pbuf[k];
                            end
                        end
                        core_d.write_enable_latch = 1'b0;
                        core_d.st = ST_BUSY;
                        core_d.tmr = PAGE_PROGRAM_CYCLES;
                    end else if (op == SECTOR_ERASE_CMD && cnt == ADDR_END_BITS && wr_ok) begin
                        // the modelled array is smaller than one sector
                        core_d.mem = {ARRAY_BYTES{ARRAY_ERASED}};
                        core_d.write_enable_latch = 1'b0;
                        core_d.st = ST_BUSY;
                        core_d.tmr = SECTOR_ERASE_CYCLES;
                    end else if ((op == BLOCK_ERASE_CMD_A || op == BLOCK_ERASE_CMD_B)
                                 && cnt == ADDR_END_BITS && wr_ok) begin
                        core_d.mem = {ARRAY_BYTES{ARRAY_ERASED}};
                        core_d.write_enable_latch = 1'b0;
                        core_d.st = ST_BUSY;
                        core_d.tmr = BLOCK_ERASE_CYCLES;
                    end else if ((op == CHIP_ERASE_CMD_A || op == CHIP_ERASE_CMD_B)
                                 && cnt == OPCODE_BITS && wr_ok) begin
                        core_d.mem = {ARRAY_BYTES{ARRAY_ERASED}};
                        core_d.write_enable_latch = 1'b0;
                        core_d.st = ST_BUSY;
                        core_d.tmr = CHIP_ERASE_CYCLES;
                    end else if (op == DEEP_POWER_DOWN_CMD && cnt == OPCODE_BITS) begin
                        core_d.st = ST_ENTER_DOWN;
                        core_d.tmr = 32'(DPD_CYC);
                    end
                end
            end
            ST_BUSY: begin
                // every frame is ignored here except for its read data
                core_d.tmr = core_q.tmr - 32'h0000_0001;
                if (core_q.tmr <= 32'h0000_0001) begin
                    core_d.st = ST_STANDBY;
                end
            end
            ST_ENTER_DOWN: begin
                core_d.tmr = core_q.tmr - 32'h0000_0001;
                if (core_q.tmr <= 32'h0000_0001) begin
                    core_d.st = ST_DEEP_DOWN;
                end
            end
            ST_DEEP_DOWN: begin
                if (cs_rise && op == SIGNATURE_READ_CMD && cnt >= OPCODE_BITS) begin
                    core_d.st = ST_WAKING;
                    core_d.tmr = 32'(WAKE_CYC);
                end
            end
            ST_WAKING: begin
                core_d.tmr = core_q.tmr - 32'h0000_0001;
                if (core_q.tmr <= 32'h0000_0001) begin
                    core_d.st = ST_STANDBY;
                end
            end
            default: core_d.st = ST_STANDBY;
        endcase
        core_d.busy = (core_d.st == ST_BUSY);
        core_d.dpd = (core_d.st == ST_DEEP_DOWN) || (core_d.st == ST_WAKING);
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            core_q.st <= ST_STANDBY;
            core_q.tmr <= 32'h0000_0000;
            core_q.write_enable_latch <= STATUS_RESET[STAT_WEL_BIT];
            core_q.prot <= STATUS_RESET[7:2];
            core_q.cs_hi <= 1'b1;
            core_q.busy <= STATUS_RESET[STAT_BUSY_BIT];
            core_q.dpd <= 1'b0;
            core_q.mem <= {ARRAY_BYTES{ARRAY_ERASED}};
        end else begin
            core_q <= core_d;
        end
    end

    assign busy_o = core_q.busy;
    assign deep_power_down_o = core_q.dpd;

endmodule : serial_flash_command_port

`default_nettype wire

// ==== tb/serial_flash_command_port_assertions.sv ====
// concurrent checks on the serial flash command port pins
`timescale 1ns/1ns
`default_nettype none

module port_rule_checker (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic sio0_o,
    input wire logic sio0_oe_o,
    input wire logic sio1_o,
    input wire logic sio1_oe_o,
    input wire logic busy_o,
    input wire logic deep_power_down_o
);
    // ==========================================================
    // rising link edges seen in the current frame, saturating
    logic [5:0] bits_q;
    always_ff @(posedge sclk_i or posedge cs_n_i or posedge sys_rst_i) begin
        if (sys_rst_i || cs_n_i) begin
            bits_q <= 6'h00;
        end else if (bits_q != 6'h3F) begin
            bits_q <= bits_q + 6'h01;
        end
    end

    // ==========================================================
    // assertions
    a_oe_deselect: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        cs_n_i |-> !sio1_oe_o && !sio0_oe_o) else $error("output enabled while deselected");
    a_dual_pair: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        sio0_oe_o |-> sio1_oe_o) else $error("even line driven alone");
    a_busy_awake: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        busy_o |-> !deep_power_down_o) else $error("busy while powered down");
    a_reset_idle: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $fell(sys_rst_i) |-> !busy_o && !deep_power_down_o) else $error("not standby at reset");
    a_busy_frame_end: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(busy_o) |-> $past(cs_n_i, 2)) else $error("busy began inside a frame");
    a_down_deselect: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(deep_power_down_o) |-> $past(cs_n_i, 8)) else $error("power-down inside a frame");
    a_wake_deselect: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $fell(deep_power_down_o) |-> $past(cs_n_i, 8)) else $error("wake inside a frame");
    a_opcode_first: assert property (@(negedge sclk_i) disable iff (sys_rst_i || cs_n_i)
        sio1_oe_o |-> bits_q >= 6'h08) else $error("output before opcode complete");
    a_dual_late: assert property (@(negedge sclk_i) disable iff (sys_rst_i || cs_n_i)
        sio0_oe_o |-> bits_q >= 6'h28) else $error("dual data before dummy byte");
endmodule : port_rule_checker

bind serial_flash_command_port port_rule_checker i_chk (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .si_i(si_i),
    .sio0_o(sio0_o), .sio0_oe_o(sio0_oe_o), .sio1_o(sio1_o), .sio1_oe_o(sio1_oe_o),
    .busy_o(busy_o), .deep_power_down_o(deep_power_down_o));

`default_nettype wire

// ==== tb/flash_host_model.sv ====
// host controller model that drives serial flash frames
`timescale 1ns/1ns
`default_nettype none

module flash_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so1_i,
    input wire logic so0_i
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end

    // ==========================================================
    // one frame: ntx bytes out, then nrx bytes in; clock idles low between frames
    task automatic frame(input logic [47:0] tx, input int ntx, input int nrx,
                         input bit dual, output logic [31:0] rx);
        int nb;
        rx = '0;
        nb = ntx * 8 + (dual ? nrx * 4 : nrx * 8);
        cs_n_o = 1'b0;
        #7;
        for (int k = 0; k < nb; k++) begin
            if (k < ntx * 8) begin
                si_o = tx[47-k];
            end else begin
                si_o = ~si_o;
            end
            #3;
            if (k >= ntx * 8) begin
                rx = dual ? {rx[29:0], so1_i, so0_i} : {rx[30:0], so1_i};
            end
            sclk_o = 1'b1;
            #3;
            sclk_o = 1'b0;
        end
        #7;
        cs_n_o = 1'b1;
        // the core takes the command up to four core cycles after deselect,
        // so the next frame must not start clocking before then
        #60;
    endtask : frame
endmodule : flash_host_model

`default_nettype wire

// ==== tb/serial_flash_command_port_bench.sv ====
// self-checking bench for the serial flash command port
`timescale 1ns/1ns
`default_nettype none

module serial_flash_command_port_bench
    import flash_cmd_pkg::*;
;
    logic mclk_i, sys_rst_i, sclk, cs_n, host_si;
    logic tog = 1'b0;
    logic sio0, sio0_oe, sio1, sio1_oe, busy, dpd;
    logic si_w, so1_w;
    logic [31:0] r;
    int n_errors = 0;
    int tests_run = 0;

    // released lines read a toggling level, never a stale value
    assign si_w = sio0_oe ? sio0 : host_si;
    assign so1_w = sio1_oe ? sio1 : tog;
    always @(posedge mclk_i) tog <= ~tog;

    serial_flash_command_port #(.STATUS_WRITE_CYCLES(120), .PAGE_PROGRAM_CYCLES(100),
        .SECTOR_ERASE_CYCLES(140), .BLOCK_ERASE_CYCLES(160), .CHIP_ERASE_CYCLES(180)) i_dut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si_w),
        .sio0_o(sio0), .sio0_oe_o(sio0_oe), .sio1_o(sio1), .sio1_oe_o(sio1_oe),
        .busy_o(busy), .deep_power_down_o(dpd));
    flash_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(host_si),
        .so1_i(so1_w), .so0_i(si_w));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // ==========================================================
    // helpers
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic xf(logic [47:0] tx, int ntx, int nrx = 0, bit dual = 1'b0);
        i_host.frame(tx, ntx, nrx, dual, r);
    endtask : xf

    task automatic rd(logic [7:0] op, logic [23:0] a, int nx, int nrx, bit d,
                      logic [31:0] e, string nm);
        xf({op, a, 16'h0000}, nx, nrx, d);
        chk(nm, e, r);
    endtask : rd

    task automatic st(logic [31:0] e, string nm);
        repeat (8) @(posedge mclk_i);
        rd(STATUS_READ_CMD, 24'h000000, 1, 1, 1'b0, e, nm);
    endtask : st

    task automatic prog(logic [23:0] a, logic [15:0] d);
        xf({WRITE_ENABLE_CMD, 40'h0}, 1);
        xf({PAGE_PROGRAM_CMD, a, d}, 6);
    endtask : prog

    task automatic bail(int n, int lim, string nm);
        if (n >= lim) begin
            n_errors++;
            $display("[FAIL] %s expected done got timeout", nm);
            finish_test();
        end
    endtask : bail

    task automatic wait_idle();
        int n;
        repeat (6) @(posedge mclk_i);
        for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge mclk_i);
        bail(n, 400, "busy_wait");
    endtask : wait_idle

    task automatic wait_dpd(logic v, output int n);
        for (n = 0; n < 1100 && dpd !== v; n++) @(posedge mclk_i);
        bail(n, 1100, "dpd_wait");
    endtask : wait_dpd

    // ==========================================================
    // scenarios
    task automatic t_delivery();
        st(32'h00, "status");
        rd(NORMAL_READ_CMD, 24'h000000, 4, 4, 1'b0, 32'hFFFFFFFF, "array");
        chk("busy_dpd", 32'h0, {30'h0, busy, dpd});
        $display("test delivery done");
    endtask : t_delivery

    task automatic t_latch();
        xf({WRITE_ENABLE_CMD, 40'h0}, 1);
        st(32'h02, "wel_set");
        xf({WRITE_DISABLE_CMD, 40'h0}, 1);
        st(32'h00, "wel_clear");
        $display("test latch done");
    endtask : t_latch

    task automatic t_ids();
        rd(READ_IDENTIFICATION_CMD, 24'h0, 1, 4, 1'b0,
           {MAKER_CODE, MEMORY_TYPE_CODE, DENSITY_CODE, DENSITY_CODE}, "ident");
        rd(MAKER_DEVICE_ID_READ_CMD, 24'h0, 4, 2, 1'b0, {16'h0, MAKER_CODE, DEVICE_CODE}, "id0");
        rd(MAKER_DEVICE_ID_READ_CMD, 24'h1, 4, 2, 1'b0, {16'h0, DEVICE_CODE, MAKER_CODE}, "id1");
        rd(SIGNATURE_READ_CMD, 24'h0, 4, 2, 1'b0, {16'h0, SIGNATURE_CODE, SIGNATURE_CODE}, "sig");
        $display("test ids done");
    endtask : t_ids

    task automatic t_program();
        prog(24'h000005, 16'h1234);
        repeat (6) @(posedge mclk_i);
        chk("busy", 32'h1, {31'h0, busy});
        st(32'h01, "busy_status");
        xf({WRITE_ENABLE_CMD, 40'h0}, 1);
        wait_idle();
        st(32'h00, "wel_ignored");
        rd(NORMAL_READ_CMD, 24'h000005, 4, 2, 1'b0, 32'h1234, "read");
        rd(FAST_READ_CMD, 24'h000005, 5, 2, 1'b0, 32'h1234, "fast");
        rd(DUAL_OUTPUT_READ_CMD, 24'h000005, 5, 2, 1'b1, 32'h1234, "dual");
        $display("test program done");
    endtask : t_program

    task automatic t_erase();
        logic [7:0] ops [5] = '{SECTOR_ERASE_CMD, BLOCK_ERASE_CMD_A, BLOCK_ERASE_CMD_B,
                                CHIP_ERASE_CMD_A, CHIP_ERASE_CMD_B};
        for (int i = 0; i < 5; i++) begin
            prog(24'h000009, 16'h0000);
            wait_idle();
            rd(NORMAL_READ_CMD, 24'h000009, 4, 1, 1'b0, 32'h00, "programmed");
            xf({WRITE_ENABLE_CMD, 40'h0}, 1);
            xf({ops[i], 24'h000009, 16'h0000}, (i < 3) ? 4 : 1);
            wait_idle();
            rd(NORMAL_READ_CMD, 24'h000009, 4, 1, 1'b0, 32'hFF, "erase");
        end
        $display("test erase done");
    endtask : t_erase

    task automatic t_power();
        int n;
        xf({DEEP_POWER_DOWN_CMD, 40'h0}, 1);
        wait_dpd(1'b1, n);
        chk("down_delay", 32'h1, {31'h0, (n >= 990 && n <= 1010)});
        xf({SIGNATURE_READ_CMD, 40'h0}, 1);
        wait_dpd(1'b0, n);
        chk("wake_delay", 32'h1, {31'h0, (n >= 870 && n <= 890)});
        $display("test power done");
    endtask : t_power

    task automatic t_status_write();
        xf({WRITE_ENABLE_CMD, 40'h0}, 1);
        xf({STATUS_WRITE_CMD, 8'hFC, 32'h0}, 2);
        wait_idle();
        st(32'hFC, "status_write");
        $display("test status write done");
    endtask : t_status_write

    initial begin
        sys_rst_i = 1'b1;
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        t_delivery();
        t_latch();
        t_ids();
        t_program();
        t_erase();
        t_power();
        t_status_write();
        finish_test();
    end
endmodule : serial_flash_command_port_bench

`default_nettype wire
